/* src/coh_pkg.sv */
package coh_pkg;
   // two-bit per-line coherence status
   typedef enum logic [1:0] {
      LINE_INVALID   = 2'h0,
      LINE_SHARED    = 2'h1,
      LINE_EXCLUSIVE = 2'h2,
      LINE_MODIFIED  = 2'h3
   } line_state_t;

   // processor request kinds
   typedef enum logic [1:0] {
      REQ_NONE  = 2'h0,
      REQ_READ  = 2'h1,
      REQ_WRITE = 2'h2
   } req_kind_t;

   // bus transaction kinds; the block issues only BUS_READ, BUS_UPGRADE and BUS_WRITE
   typedef enum logic [2:0] {
      BUS_IDLE       = 3'h0,
      BUS_READ       = 3'h1,
      BUS_READ_OWN   = 3'h2,
      BUS_UPGRADE    = 3'h3,
      BUS_WRITE      = 3'h4,
      BUS_WRITEBACK  = 3'h5
   } bus_kind_t;

   // snoop request kinds arriving from the system bus
   typedef enum logic [1:0] {
      SNP_NONE  = 2'h0,
      SNP_READ  = 2'h1,
      SNP_INVAL = 2'h2
   } snoop_kind_t;

   localparam int          CD_BIT       = 30;
   localparam int          NW_BIT       = 29;
   localparam int          LINE_INDEX_W = 4;
   localparam int          TAG_W        = 8;
   localparam logic [31:0] CTRL_RESET   = 32'h6000_0010;
endpackage

/* src/coh_state_if.sv */
// carries the state array port between the controller and its memory
interface coh_state_if #(
   parameter int IDX_W = 4,
   parameter int TAG_W = 8
);
   logic             rd_en;
   logic [IDX_W-1:0] rd_idx;
   logic [1:0]       rd_state;
   logic [TAG_W-1:0] rd_tag;
   logic             wr_en;
   logic [IDX_W-1:0] wr_idx;
   logic [1:0]       wr_state;
   logic [TAG_W-1:0] wr_tag;

   modport ctrl (output rd_en, output rd_idx, input rd_state, input rd_tag,
                 output wr_en, output wr_idx, output wr_state, output wr_tag);
   modport mem  (input rd_en, input rd_idx, output rd_state, output rd_tag,
                 input wr_en, input wr_idx, input wr_state, input wr_tag);
endinterface

/* src/coh_state_mem.sv */
// per-line tag and status storage with registered read data
module coh_state_mem
   import coh_pkg::*;
#(
   parameter int IDX_W = 4,
   parameter int TAG_W = 8
) (
   input  wire logic  clk_i,
   input  wire logic  reset_i,
   coh_state_if.mem   port
);
   localparam int DEPTH = 1 << IDX_W;

   typedef struct packed {
      logic [DEPTH-1:0][1:0]       state;
      logic [DEPTH-1:0][TAG_W-1:0] tag;
      logic [1:0]                  rd_state;
      logic [TAG_W-1:0]            rd_tag;
   } mem_t;

   mem_t r;
   mem_t next_r;

   // write first so a same-cycle read sees the fresh status
   always_comb begin
      next_r = r;
      if (port.wr_en) begin
         next_r.state[port.wr_idx] = port.wr_state;
         next_r.tag[port.wr_idx]   = port.wr_tag;
      end
      if (port.rd_en) begin
         next_r.rd_state = next_r.state[port.rd_idx];
         next_r.rd_tag   = next_r.tag[port.rd_idx];
      end
   end

   // every line starts invalid
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign port.rd_state = r.rd_state;
   assign port.rd_tag   = r.rd_tag;
endmodule

/* src/coh_ctrl.sv */
// Functional notes
// RULE1: every data/unified cache line carries a two-bit status for M, E, S or I.
// RULE2: M, E and S lines hold valid data, I does not; memory is stale only for M.
// RULE3: M or E means no other cache has a copy; S or I allows other copies.
// RULE4: a write hitting an M or E line completes locally with no bus transaction.
// RULE5: a write to an S line first gains exclusive ownership over the bus.
// RULE6: a write to an I line goes straight to the system bus.
// RULE7: the instruction cache is never written and uses only shared and invalid.
// RULE8: the instruction cache watches data-cache writes to stay consistent.
// RULE9: with the cache-disable flag (control bit 30) clear, caching is allowed.
// RULE10: with the cache-disable flag set, caching is restricted (no fills).
// RULE11: snoops are still answered while the cache-disable flag is set.
// RULE12: software should flush the caches after setting the cache-disable flag.
// RULE13: software should keep cache-disable and no-write-through clear for speed.
// RULE14: the cache-disable flag alone does not force strict access ordering.
// RULE15: the caches run the four-state invalidation protocol with peer caches.
// RULE16: with both flags clear, read hits serve from cache, misses fill, writes update.
// RULE17: a completed write to an E line, or an S line after ownership, leaves it M.
module coh_ctrl
   import coh_pkg::*;
(
   input  wire logic                          clk_i,
   input  wire logic                          reset_i,
   input  wire logic                          ctrl_we_i,
   input  wire logic [31:0]                   ctrl_wdata_i,
   output logic      [31:0]                   ctrl_o,
   input  wire coh_pkg::req_kind_t            req_kind_i,
   input  wire logic [coh_pkg::LINE_INDEX_W-1:0] req_idx_i,
   input  wire logic [coh_pkg::TAG_W-1:0]     req_tag_i,
   output logic                               req_ready_o,
   output logic                               req_done_o,
   output logic                               req_hit_o,
   output logic                               req_cached_o,
   output coh_pkg::bus_kind_t                 bus_kind_o,
   output logic [coh_pkg::LINE_INDEX_W-1:0]   bus_idx_o,
   output logic [coh_pkg::TAG_W-1:0]          bus_tag_o,
   input  wire logic                          bus_ack_i,
   input  wire logic                          bus_shared_i,
   input  wire coh_pkg::snoop_kind_t          snoop_kind_i,
   input  wire logic [coh_pkg::LINE_INDEX_W-1:0] snoop_idx_i,
   input  wire logic [coh_pkg::TAG_W-1:0]     snoop_tag_i,
   output logic                               snoop_done_o,
   output logic                               snoop_hit_o,
   output logic                               snoop_dirty_o,
   output logic                               icache_inval_o,
   output logic [coh_pkg::LINE_INDEX_W-1:0]   icache_idx_o
);
   import coh_pkg::*;

   typedef enum logic [5:0] {
      ST_IDLE   = 6'h01,
      ST_LOOKUP = 6'h02,
      ST_BUS    = 6'h04,
      ST_SNP_RD = 6'h08,
      ST_SNP_WB = 6'h10,
      ST_DONE   = 6'h20
   } fsm_t;

   typedef struct packed {
      fsm_t                    fsm;
      logic [31:0]             ctrl;
      req_kind_t               kind;
      logic [LINE_INDEX_W-1:0] idx;
      logic [TAG_W-1:0]        tag;
      snoop_kind_t             snp;
      logic [1:0]              new_state;
      logic                    wr_line;
      logic                    ready;
      logic                    done;
      logic                    hit;
      logic                    cached;
      bus_kind_t               bus;
      logic                    snp_done;
      logic                    snp_hit;
      logic                    snp_dirty;
      logic                    ic_inval;
   } ctrl_t;

   ctrl_t r;
   ctrl_t next_r;

   coh_state_if #(.IDX_W(LINE_INDEX_W), .TAG_W(TAG_W)) st_port ();

   coh_state_mem #(.IDX_W(LINE_INDEX_W), .TAG_W(TAG_W)) u_mem (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .port    (st_port)
   );

   // valid-data test shared by request and snoop paths
   function automatic logic line_valid(input logic [1:0] s);
      return s != LINE_INVALID; // RULE2
   endfunction

   // hit test: valid status and matching tag
   function automatic logic line_hit(input logic [1:0] s, input logic [TAG_W-1:0] a,
                                     input logic [TAG_W-1:0] b);
      return line_valid(s) && (a == b);
   endfunction

   wire logic cd_set = r.ctrl[CD_BIT]; // RULE9
   wire logic lhit   = line_hit(st_port.rd_state, st_port.rd_tag, r.tag);

   // array read port driven from the live snoop or request inputs, write port from the registered request or snoop
   always_comb begin
      st_port.rd_en    = (r.fsm == ST_IDLE);
      st_port.rd_idx   = (snoop_kind_i != SNP_NONE) ? snoop_idx_i : req_idx_i;
      st_port.wr_en    = r.wr_line;
      st_port.wr_idx   = r.idx;
      st_port.wr_state = r.new_state; // RULE1
      st_port.wr_tag   = r.tag;
   end

   // main controller; snoops take priority over processor requests
   always_comb begin
      next_r          = r;
      next_r.wr_line  = 1'b0;
      next_r.done     = 1'b0;
      next_r.snp_done = 1'b0;
      next_r.ic_inval = 1'b0;
      if (ctrl_we_i) begin
         next_r.ctrl = ctrl_wdata_i; // RULE14
      end
      unique case (r.fsm)
         ST_IDLE: begin
            next_r.ready = 1'b1;
            if (snoop_kind_i != SNP_NONE) begin
               // snoops proceed regardless of the disable flag
               next_r.snp   = snoop_kind_i; // RULE11
               next_r.idx   = snoop_idx_i;
               next_r.tag   = snoop_tag_i;
               next_r.ready = 1'b0;
               next_r.fsm   = ST_SNP_RD;
            end else if (req_kind_i != REQ_NONE && r.ready) begin
               next_r.kind  = req_kind_i;
               next_r.idx   = req_idx_i;
               next_r.tag   = req_tag_i;
               next_r.ready = 1'b0;
               next_r.fsm   = ST_LOOKUP;
            end
         end
         ST_LOOKUP: begin
            next_r.hit    = lhit;
            next_r.cached = 1'b0;
            if (r.kind == REQ_READ) begin
               if (lhit) begin
                  next_r.cached = 1'b1; // RULE16
                  next_r.fsm    = ST_DONE;
               end else begin
                  // miss: fill only while caching allowed
                  next_r.bus = BUS_READ; // RULE16
                  next_r.fsm = ST_BUS;
               end
            end else begin
               // data write: instruction side drops any copy
               next_r.ic_inval = 1'b1; // RULE8
               if (lhit && (st_port.rd_state == LINE_MODIFIED ||
                            st_port.rd_state == LINE_EXCLUSIVE)) begin
                  next_r.cached    = 1'b1; // RULE4
                  next_r.new_state = LINE_MODIFIED; // RULE17
                  next_r.wr_line   = 1'b1; // RULE16
                  next_r.fsm       = ST_DONE;
               end else if (lhit) begin
                  next_r.bus = BUS_UPGRADE; // RULE5
                  next_r.fsm = ST_BUS;
               end else begin
                  next_r.bus = BUS_WRITE; // RULE6
                  next_r.fsm = ST_BUS;
               end
            end
         end
         ST_BUS: begin
            if (bus_ack_i) begin
               next_r.bus = BUS_IDLE;
               next_r.fsm = ST_DONE;
               if (r.bus == BUS_UPGRADE) begin
                  // peers invalidated, line now owned
                  next_r.cached    = 1'b1;
                  next_r.new_state = LINE_MODIFIED; // RULE17
                  next_r.wr_line   = 1'b1; // RULE15
               end else if (r.bus == BUS_READ && !cd_set) begin
                  // a peer copy leaves the line shared
                  next_r.new_state = bus_shared_i ? LINE_SHARED
                                                  : LINE_EXCLUSIVE; // RULE3
                  next_r.wr_line   = 1'b1; // RULE10
                  next_r.cached    = 1'b1; // RULE16
               end
            end
         end
         ST_SNP_RD: begin
            next_r.snp_hit   = lhit;
            next_r.snp_dirty = lhit && (st_port.rd_state == LINE_MODIFIED); // RULE2
            next_r.fsm       = ST_SNP_WB;
            if (lhit) begin
               // read snoop demotes, invalidating snoop drops
               next_r.new_state = (r.snp == SNP_READ) ? LINE_SHARED
                                                      : LINE_INVALID; // RULE15
               next_r.wr_line   = 1'b1;
            end
         end
         ST_SNP_WB: begin
            next_r.snp_done = 1'b1; // RULE11
            next_r.fsm      = ST_IDLE;
         end
         ST_DONE: begin
            next_r.done = 1'b1;
            next_r.fsm  = ST_IDLE;
         end
         default: begin
            next_r.fsm = ST_IDLE;
         end
      endcase
   end

   // single state register; reset leaves caching disabled like a cold start
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         r       <= '0;
         r.fsm   <= ST_IDLE;
         r.ctrl  <= CTRL_RESET;
         r.kind  <= REQ_NONE;
         r.snp   <= SNP_NONE;
         r.bus   <= BUS_IDLE;
      end else begin
         r <= next_r;
      end
   end

   // outputs straight from flip-flops
   assign ctrl_o         = r.ctrl;
   assign req_ready_o    = r.ready;
   assign req_done_o     = r.done;
   assign req_hit_o      = r.hit;
   assign req_cached_o   = r.cached;
   assign bus_kind_o     = r.bus;
   assign bus_idx_o      = r.idx;
   assign bus_tag_o      = r.tag;
   assign snoop_done_o   = r.snp_done;
   assign snoop_hit_o    = r.snp_hit;
   assign snoop_dirty_o  = r.snp_dirty;
   assign icache_inval_o = r.ic_inval; // RULE7
   assign icache_idx_o   = r.idx;
endmodule

/* tb/coh_ctrl_sva.sv */
// protocol checks on the controller's own ports
module coh_ctrl_sva
   import coh_pkg::*;
(
   input wire logic                        clk_i,
   input wire logic                        reset_i,
   input wire logic [31:0]                 ctrl_o,
   input wire coh_pkg::req_kind_t          req_kind_i,
   input wire logic [coh_pkg::LINE_INDEX_W-1:0] req_idx_i,
   input wire logic                        req_ready_o,
   input wire logic                        req_done_o,
   input wire logic                        req_hit_o,
   input wire logic                        req_cached_o,
   input wire coh_pkg::bus_kind_t          bus_kind_o,
   input wire logic [coh_pkg::LINE_INDEX_W-1:0] bus_idx_o,
   input wire logic                        bus_ack_i,
   input wire coh_pkg::snoop_kind_t        snoop_kind_i,
   input wire logic                        snoop_done_o,
   input wire logic                        icache_inval_o,
   input wire logic [coh_pkg::LINE_INDEX_W-1:0] icache_idx_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);

   // a request is taken only when idle and no snoop competes
   sequence take_s;
      req_kind_i != REQ_NONE && req_ready_o && snoop_kind_i == SNP_NONE;
   endsequence
   sequence acked_s;
      bus_ack_i && bus_kind_o != BUS_IDLE;
   endsequence

   a_local_done: assert property (take_s ##2 bus_kind_o == BUS_IDLE |=> req_done_o)
      else $error("local access not done in time");
   a_bus_done: assert property (acked_s |=> bus_kind_o == BUS_IDLE ##1 req_done_o)
      else $error("bus access not closed in time");
   a_upgrade_write: assert property (bus_kind_o == BUS_UPGRADE |-> req_kind_i == REQ_WRITE)
      else $error("ownership request without a write");
   a_write_bus_idx: assert property (bus_kind_o == BUS_WRITE |-> bus_idx_o == req_idx_i)
      else $error("bus write for wrong line");
   a_bus_stands: assert property (bus_kind_o != BUS_IDLE && !bus_ack_i |=> $stable(bus_kind_o))
      else $error("bus request changed before ack");
   a_snoop_time: assert property (snoop_kind_i != SNP_NONE && req_ready_o |-> ##3 snoop_done_o)
      else $error("snoop not answered in time");
   a_icache_src: assert property (icache_inval_o |->
      icache_idx_o == $past(req_idx_i) && $past(req_kind_i) == REQ_WRITE)
      else $error("icache notice without matching write");
   a_no_fill_cd: assert property (req_done_o && req_kind_i == REQ_READ && !req_hit_o
      && ctrl_o[CD_BIT] |-> !req_cached_o)
      else $error("line filled while caching disabled");
   a_done_ready: assert property (req_done_o |=> !req_done_o && req_ready_o)
      else $error("done not a pulse or ready late");
endmodule

bind coh_ctrl coh_ctrl_sva coh_ctrl_sva_inst (.*);

/* tb/coh_bus_peer.sv */
// far side of the system bus: acks each transaction once, fast or slow
module coh_bus_peer
   import coh_pkg::*;
(
   input  wire logic      clk_i,
   input  wire logic      reset_i,
   input  wire bus_kind_t bus_kind_i,
   input  wire logic      share_i,
   input  wire logic      slow_i,
   output logic           bus_ack_o = 1'b0,
   output logic           bus_shared_o = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   int wait_n = 0;

   // shared line toggles outside the ack so a stale value never reads as valid
   always @(negedge clk_i) begin
      if (reset_i || bus_kind_i == BUS_IDLE || bus_ack_o) begin
         bus_ack_o    <= 1'b0;
         wait_n       <= slow_i ? 6 : 0;
         bus_shared_o <= ~bus_shared_o;
      end else if (wait_n > 0) begin
         wait_n       <= wait_n - 1;
         bus_shared_o <= ~bus_shared_o;
      end else begin
         bus_ack_o    <= 1'b1;
         bus_shared_o <= share_i;
      end
   end
endmodule

/* tb/tb.sv */
module tb
   import coh_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0, reset_i = 1'b1, ctrl_we_i = 1'b0, share = 1'b0, slow = 1'b0;
   logic [31:0] ctrl_wdata_i = 32'h0, ctrl_o;
   req_kind_t   req_kind_i = REQ_NONE;
   snoop_kind_t snoop_kind_i = SNP_NONE;
   bus_kind_t   bus_kind_o;
   logic [LINE_INDEX_W-1:0] req_idx_i = '0, snoop_idx_i = '0, bus_idx_o, icache_idx_o;
   logic [TAG_W-1:0]        req_tag_i = '0, snoop_tag_i = '0, bus_tag_o;
   logic req_ready_o, req_done_o, req_hit_o, req_cached_o, bus_ack_i, bus_shared_i;
   logic snoop_done_o, snoop_hit_o, snoop_dirty_o, icache_inval_o;
   line_state_t      st[16];
   logic [TAG_W-1:0] tg[16];
   logic             cd = 1'b1;
   int bad_count = 0, total_checks = 0, cycles = 0;

   coh_ctrl coh_ctrl_inst (.*);
   coh_bus_peer coh_bus_peer_inst (.clk_i(clk_i), .reset_i(reset_i), .bus_kind_i(bus_kind_o),
      .share_i(share), .slow_i(slow), .bus_ack_o(bus_ack_i), .bus_shared_o(bus_shared_i));

   initial forever #20 clk_i = ~clk_i;

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // hang guard, far above the few hundred cycles the run needs
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         summarize();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic wctrl(input logic [31:0] v);
      ctrl_we_i = 1'b1;
      ctrl_wdata_i = v;
      @(negedge clk_i);
      ctrl_we_i = 1'b0;
      cd = v[CD_BIT];
      chk(ctrl_o, v, "control");
   endtask

   // one processor access, held until done; model predicts bus use and next state
   task automatic req(input req_kind_t k, input int i);
      line_state_t s;
      bus_kind_t   eb, seen;
      int          n;
      int          ic;
      s = st[i];
      ic = 0;
      seen = BUS_IDLE;
      share = 1'($urandom_range(1));
      slow = 1'($urandom_range(1));
      if (k == REQ_READ) eb = (s != LINE_INVALID) ? BUS_IDLE : BUS_READ;
      else eb = (s == LINE_SHARED) ? BUS_UPGRADE : (s == LINE_INVALID) ? BUS_WRITE : BUS_IDLE;
      n = 0;
      while (req_ready_o !== 1'b1 && n < 20) begin @(negedge clk_i); n++; end
      req_kind_i = k;
      req_idx_i = i[LINE_INDEX_W-1:0];
      req_tag_i = tg[i];
      n = 0;
      do begin
         @(negedge clk_i);
         if (bus_kind_o !== BUS_IDLE) begin
            seen = bus_kind_o;
            chk({bus_idx_o, bus_tag_o}, {i[LINE_INDEX_W-1:0], tg[i]}, "bus line");
         end
         if (icache_inval_o === 1'b1) ic++;
         n++;
      end while (req_done_o !== 1'b1 && n < 40);
      req_kind_i = REQ_NONE;
      chk(seen, eb, "bus kind");
      chk(req_hit_o, s != LINE_INVALID, "hit");
      chk(ic, k == REQ_WRITE, "icache notice");
      if (k == REQ_READ && !(s != LINE_INVALID && cd))
         chk(req_cached_o, s != LINE_INVALID || !cd, "cached");
      if (k == REQ_WRITE && s != LINE_INVALID) st[i] = LINE_MODIFIED;
      if (k == REQ_READ && s == LINE_INVALID && !cd) st[i] = share ? LINE_SHARED : LINE_EXCLUSIVE;
   endtask

   // one snoop, sometimes with a foreign tag so it must miss
   task automatic snoop(input snoop_kind_t k, input int i);
      logic [TAG_W-1:0] t;
      logic             h;
      int               n;
      t = ($urandom_range(3) == 0) ? tg[i] ^ 8'h01 : tg[i];
      h = st[i] != LINE_INVALID && t == tg[i];
      n = 0;
      while (req_ready_o !== 1'b1 && n < 20) begin @(negedge clk_i); n++; end
      snoop_kind_i = k;
      snoop_idx_i = i[LINE_INDEX_W-1:0];
      snoop_tag_i = t;
      @(negedge clk_i);
      snoop_kind_i = SNP_NONE;
      n = 0;
      while (snoop_done_o !== 1'b1 && n < 20) begin @(negedge clk_i); n++; end
      chk(snoop_hit_o, h, "snoop hit");
      chk(snoop_dirty_o, h && st[i] == LINE_MODIFIED, "snoop dirty");
      if (h) st[i] = (k == SNP_READ) ? LINE_SHARED : LINE_INVALID;
   endtask

   // main sequence: disabled, mixed traffic, disabled again after fills
   initial begin
      int n;
      n = $urandom(47802);
      foreach (st[i]) begin
         st[i] = LINE_INVALID;
         tg[i] = 8'($urandom_range(255));
      end
      repeat (8) @(negedge clk_i);
      reset_i = 1'b0;
      @(negedge clk_i);
      chk(ctrl_o, CTRL_RESET, "reset control");
      chk(req_ready_o, 1'b1, "ready after reset");
      for (n = 0; n < 4; n++) req(REQ_READ, n);
      for (n = 0; n < 2; n++) snoop(SNP_READ, n);
      $display("test disabled cache done");
      wctrl(32'h0000_0010);
      repeat (80) begin
         n = $urandom_range(3);
         if (n < 2) req(n == 0 ? REQ_READ : REQ_WRITE, $urandom_range(3));
         else snoop(n == 2 ? SNP_READ : SNP_INVAL, $urandom_range(3));
      end
      $display("test mixed traffic done");
      wctrl(CTRL_RESET);
      for (n = 0; n < 4; n++) req(REQ_READ, n);
      for (n = 0; n < 4; n++) snoop(SNP_INVAL, n);
      $display("test disable after fill done");
      summarize();
   end
endmodule
